// >>> logic/acr_pkg.sv
package acr_pkg;
  // Result width and serial framing
  localparam int ACR_DATA_W = 16;
  localparam logic [4:0] ACR_BITS_PLAIN = 5'h10;
  localparam logic [4:0] ACR_BITS_BUSY = 5'h11;
  localparam logic [4:0] ACR_BIT_ZERO = 5'h00;
  // Conversion times in ns, counted in clk_sys cycles of 100 ns
  localparam int ACR_CLK_NS = 100;
  localparam int ACR_TCONV_MIN_NS = 500;
  localparam int ACR_TCONV_MAX_NS = 710;
  localparam int ACR_CONV_MIN_CYC = (ACR_TCONV_MIN_NS + ACR_CLK_NS - 1) / ACR_CLK_NS;
  localparam int ACR_CONV_MAX_CYC = (ACR_TCONV_MAX_NS / ACR_CLK_NS < 1) ? 1 :
                                    ACR_TCONV_MAX_NS / ACR_CLK_NS;
  localparam logic [7:0] ACR_CONV_CNT = 8'(ACR_CONV_MAX_CYC);
  localparam logic [7:0] ACR_CNT_ZERO = 8'h00;
  // Host serial clock divider: half period is this count plus one clk_sys cycle (slow link)
  localparam logic [3:0] ACR_SCK_HALF = 4'h4;
  localparam logic [3:0] ACR_DIV_ZERO = 4'h0;
  localparam logic [15:0] ACR_WORD_ZERO = 16'h0000;
  localparam logic [1:0] ACR_SYNC_IDLE = 2'h0;
  // Idle level of lines that rest high (select, pulled-up data line)
  localparam logic [1:0] ACR_SYNC_HIGH = 2'h3;

  // Device conversion states
  typedef enum logic [1:0]
  {
    ACR_D_IDLE = 2'b00,
    ACR_D_CONV = 2'b01,
    ACR_D_ACQ = 2'b10
  } acr_dev_state_t;

  // Host sequencing states
  typedef enum logic [2:0]
  {
    ACR_H_IDLE = 3'b000,
    ACR_H_CONV = 3'b001,
    ACR_H_WAITB = 3'b010,
    ACR_H_SEL = 3'b011,
    ACR_H_SHIFT = 3'b100,
    ACR_H_DONE = 3'b101
  } acr_host_state_t;
endpackage

// >>> logic/acr_link_if.sv
`timescale 1ns/1ps
interface acr_link_if;
  logic convert_start;
  logic select_chain_input;
  logic sck;
  logic serial_data_out_o;
  logic serial_data_out_oe_n;
  // Resolved line with a pull-up when nobody drives
  logic serial_data_line;
  assign serial_data_line = serial_data_out_oe_n ? 1'b1 : serial_data_out_o;

  modport dev
  (
    input convert_start,
    input select_chain_input,
    input sck,
    output serial_data_out_o,
    output serial_data_out_oe_n
  );

  modport host
  (
    output convert_start,
    output select_chain_input,
    output sck,
    input serial_data_line
  );
endinterface

// >>> logic/acr_device.sv
`timescale 1ns/1ps
module acr_device
  import acr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  acr_link_if.dev link,
  input wire logic [15:0] sample_in,
  output logic cs_mode,
  output logic converting,
  output logic conv_done
);

  logic [1:0] cnv_sync_reg;
  logic [1:0] sel_sync_reg;
  logic [1:0] sck_sync_reg;
  logic cnv_d_reg;
  logic sel_d_reg;
  logic sck_d_reg;
  acr_dev_state_t state_reg;
  logic [7:0] conv_cnt_reg;
  logic [15:0] shift_reg;
  logic [4:0] bits_left_reg;
  logic busy_mode_reg;
  logic active_reg;
  logic drive_n_reg;
  logic dout_reg;
  logic cnv_rise;
  logic cnv_fall;
  logic sel_rise;
  logic sel_fall;
  logic sck_fall;
  logic sel_both_low;
  logic read_open;

  // Two-flop synchronisers for all pins from the host
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      cnv_sync_reg <= ACR_SYNC_IDLE;
      // Select rests high: a low reset value would fake a select edge
      sel_sync_reg <= ACR_SYNC_HIGH;
      sck_sync_reg <= ACR_SYNC_IDLE;
      cnv_d_reg <= 1'b0;
      sel_d_reg <= 1'b1;
      sck_d_reg <= 1'b0;
    end
    else
    begin
      cnv_sync_reg <= {cnv_sync_reg[0], link.convert_start};
      sel_sync_reg <= {sel_sync_reg[0], link.select_chain_input};
      sck_sync_reg <= {sck_sync_reg[0], link.sck};
      cnv_d_reg <= cnv_sync_reg[1];
      sel_d_reg <= sel_sync_reg[1];
      sck_d_reg <= sck_sync_reg[1];
    end
  end

  // Edge detection looks only at second stage and its delayed copy
  assign cnv_rise = cnv_sync_reg[1] & ~cnv_d_reg;
  assign cnv_fall = ~cnv_sync_reg[1] & cnv_d_reg;
  assign sel_rise = sel_sync_reg[1] & ~sel_d_reg;
  assign sel_fall = ~sel_sync_reg[1] & sel_d_reg;
  assign sck_fall = ~sck_sync_reg[1] & sck_d_reg;
  assign sel_both_low = ~cnv_sync_reg[1] & ~sel_sync_reg[1];
  // Read opens when start falls (3-wire) or select falls (4-wire, start high)
  assign read_open = cnv_fall | (sel_fall & cnv_sync_reg[1]);

  // Conversion sequencing; internal timing uses the max count
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= ACR_D_IDLE;
      conv_cnt_reg <= ACR_CNT_ZERO;
      cs_mode <= 1'b0;
    end
    else if (cnv_rise)
    begin
      // Mode latched from select; chain mode is not modelled here
      cs_mode <= sel_sync_reg[1];
      if (sel_sync_reg[1])
      begin
        state_reg <= ACR_D_CONV;
        conv_cnt_reg <= ACR_CONV_CNT;
      end
    end
    else
    begin
      unique case (state_reg)
        ACR_D_IDLE:
          state_reg <= ACR_D_IDLE;
        ACR_D_CONV:
        begin
          // Start level is ignored until the count runs out
          if (conv_cnt_reg == 8'h01)
            state_reg <= ACR_D_ACQ;
          conv_cnt_reg <= conv_cnt_reg - 8'h01;
        end
        ACR_D_ACQ:
          state_reg <= ACR_D_ACQ;
        default:
          state_reg <= ACR_D_IDLE;
      endcase
    end
  end

  // Readout shifter and output driver; the enable is kept active low so the pin is a flop
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      shift_reg <= ACR_WORD_ZERO;
      bits_left_reg <= ACR_BIT_ZERO;
      busy_mode_reg <= 1'b0;
      active_reg <= 1'b0;
      drive_n_reg <= 1'b1;
      dout_reg <= 1'b0;
      conv_done <= 1'b0;
    end
    else
    begin
      conv_done <= 1'b0;
      if (cnv_rise && sel_sync_reg[1])
      begin
        active_reg <= 1'b0;
        drive_n_reg <= 1'b1;
      end
      else if (state_reg == ACR_D_CONV && conv_cnt_reg == 8'h01)
      begin
        conv_done <= 1'b1;
        shift_reg <= sample_in;
        busy_mode_reg <= sel_both_low | ~cnv_sync_reg[1] | ~sel_sync_reg[1];
        if (~cnv_sync_reg[1] | ~sel_sync_reg[1])
        begin
          // Busy start bit: drive low as interrupt edge
          active_reg <= 1'b1;
          drive_n_reg <= 1'b0;
          dout_reg <= 1'b0;
          bits_left_reg <= ACR_BITS_BUSY;
        end
        else
          bits_left_reg <= ACR_BITS_PLAIN;
      end
      else if (active_reg && (cnv_rise || (sel_rise && cnv_sync_reg[1])))
      begin
        active_reg <= 1'b0;
        drive_n_reg <= 1'b1;
      end
      else if (active_reg && sck_fall)
      begin
        // Counter holds the falls still due; the last one only releases the line
        dout_reg <= shift_reg[ACR_DATA_W-1];
        shift_reg <= {shift_reg[ACR_DATA_W-2:0], 1'b0};
        bits_left_reg <= bits_left_reg - 5'h01;
        if (bits_left_reg == 5'h01)
        begin
          active_reg <= 1'b0;
          drive_n_reg <= 1'b1;
        end
      end
      else if (state_reg == ACR_D_ACQ && !active_reg && !busy_mode_reg && read_open
               && bits_left_reg == ACR_BITS_PLAIN)
      begin
        // MSB is out before any fall, so all 16 falls stay due
        active_reg <= 1'b1;
        drive_n_reg <= 1'b0;
        dout_reg <= shift_reg[ACR_DATA_W-1];
        shift_reg <= {shift_reg[ACR_DATA_W-2:0], 1'b0};
      end
      else if (!active_reg)
      begin
        // Idle line with both inputs low is held low outside conversion, not floating
        drive_n_reg <= ~(sel_both_low && state_reg != ACR_D_CONV);
        dout_reg <= 1'b0;
      end
    end
  end

  // Plain mode: the first of 16 bits leaves on the read-open edge
  assign link.serial_data_out_o = dout_reg;
  assign link.serial_data_out_oe_n = drive_n_reg;

  // Converter powered only while converting
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      converting <= 1'b0;
    else
      converting <= (state_reg == ACR_D_CONV);
  end

endmodule

// >>> logic/acr_host.sv
`timescale 1ns/1ps
module acr_host
  import acr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  acr_link_if.host link,
  input wire logic start,
  input wire logic four_wire,
  input wire logic use_busy,
  output logic [15:0] result,
  output logic result_valid,
  output logic host_busy
);

  acr_host_state_t state_reg;
  logic [7:0] wait_reg;
  logic [3:0] div_reg;
  logic [4:0] edges_reg;
  logic [15:0] rx_reg;
  logic [1:0] sdo_sync_reg;
  logic cnv_reg;
  logic sel_reg;
  logic sck_reg;
  logic wire4_reg;
  logic busy_reg;

  assign link.convert_start = cnv_reg;
  assign link.select_chain_input = sel_reg;
  assign link.sck = sck_reg;

  // Data line comes from another party: two flops before use
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      sdo_sync_reg <= ACR_SYNC_HIGH;
    else
      sdo_sync_reg <= {sdo_sync_reg[0], link.serial_data_line};
  end

  // Sequencer; the device sees pins through two flops, so spacing is slow
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= ACR_H_IDLE;
      wait_reg <= ACR_CNT_ZERO;
      div_reg <= ACR_DIV_ZERO;
      edges_reg <= ACR_BIT_ZERO;
      rx_reg <= ACR_WORD_ZERO;
      cnv_reg <= 1'b0;
      sel_reg <= 1'b1;
      sck_reg <= 1'b0;
      wire4_reg <= 1'b0;
      busy_reg <= 1'b0;
      result <= ACR_WORD_ZERO;
      result_valid <= 1'b0;
      host_busy <= 1'b0;
    end
    else
    begin
      result_valid <= 1'b0;
      unique case (state_reg)
        ACR_H_IDLE:
          if (start)
          begin
            wire4_reg <= four_wire;
            busy_reg <= use_busy;
            // Plain modes keep both lines high through the whole wait
            sel_reg <= 1'b1;
            cnv_reg <= 1'b1;
            host_busy <= 1'b1;
            wait_reg <= ACR_CONV_CNT + 8'h04;
            div_reg <= ACR_SCK_HALF;
            state_reg <= ACR_H_CONV;
          end
        ACR_H_CONV:
        begin
          // Busy mode: drop the chosen line once start is seen
          if (busy_reg && div_reg == ACR_DIV_ZERO)
          begin
            if (wire4_reg)
              sel_reg <= 1'b0;
            else
              cnv_reg <= 1'b0;
          end
          if (div_reg != ACR_DIV_ZERO)
            div_reg <= div_reg - 4'h1;
          if (busy_reg)
            state_reg <= ACR_H_WAITB;
          else if (wait_reg == ACR_CNT_ZERO)
            state_reg <= ACR_H_SEL;
          else
            wait_reg <= wait_reg - 8'h01;
        end
        ACR_H_WAITB:
        begin
          if (div_reg != ACR_DIV_ZERO)
            div_reg <= div_reg - 4'h1;
          else if (wire4_reg)
            sel_reg <= 1'b0;
          else
            cnv_reg <= 1'b0;
          // Low on the pulled-up line is the busy edge
          if (!sdo_sync_reg[1] && div_reg == ACR_DIV_ZERO)
          begin
            edges_reg <= ACR_BITS_BUSY;
            div_reg <= ACR_SCK_HALF;
            state_reg <= ACR_H_SHIFT;
          end
        end
        ACR_H_SEL:
        begin
          // Four-wire keeps start high and opens with select
          if (wire4_reg)
            sel_reg <= 1'b0;
          else
            cnv_reg <= 1'b0;
          edges_reg <= ACR_BITS_PLAIN;
          div_reg <= ACR_SCK_HALF;
          state_reg <= ACR_H_SHIFT;
        end
        ACR_H_SHIFT:
        begin
          if (div_reg != ACR_DIV_ZERO)
            div_reg <= div_reg - 4'h1;
          else
          begin
            div_reg <= ACR_SCK_HALF;
            sck_reg <= ~sck_reg;
            // Sample as sck falls: the bit has stood a half period, which covers the
            // device's input flops and our own two; a rising sample would see the old bit
            if (sck_reg && edges_reg != ACR_BITS_BUSY)
              rx_reg <= {rx_reg[14:0], sdo_sync_reg[1]};
            if (sck_reg)
            begin
              edges_reg <= edges_reg - 5'h01;
              if (edges_reg == 5'h01)
                state_reg <= ACR_H_DONE;
            end
          end
        end
        ACR_H_DONE:
        begin
          // Release promptly so a shared line is not contended
          cnv_reg <= 1'b0;
          sel_reg <= 1'b1;
          result <= rx_reg;
          result_valid <= 1'b1;
          host_busy <= 1'b0;
          state_reg <= ACR_H_IDLE;
        end
        default:
          state_reg <= ACR_H_IDLE;
      endcase
    end
  end

endmodule

// >>> verif/acr_link_properties.sv
`timescale 1ns/1ps
module acr_link_properties
  import acr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic convert_start,
  input wire logic select_chain_input,
  input wire logic sck,
  input wire logic serial_data_out_o,
  input wire logic serial_data_out_oe_n
);
  logic sck_reg;
  logic [4:0] falls_reg;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // Serial clock falls seen while the output drives; cleared whenever the line is released
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      sck_reg <= 1'b0;
      falls_reg <= ACR_BIT_ZERO;
    end
    else
    begin
      sck_reg <= sck;
      if (serial_data_out_oe_n)
        falls_reg <= ACR_BIT_ZERO;
      else if (sck_reg && !sck)
        falls_reg <= falls_reg + 5'h01;
    end
  end

  // Window stops before the earliest busy bit, so the busy modes do not trip it
  start_tristate_a: assert property ($rose(convert_start) && select_chain_input
    |-> ##4 serial_data_out_oe_n [*5]) else $error("output driven during conversion");
  start_release_a: assert property ($rose(convert_start) |-> ##[1:4] serial_data_out_oe_n)
    else $error("output not released on start rising");
  select_release_a: assert property ($rose(select_chain_input)
    |-> ##[1:4] serial_data_out_oe_n) else $error("output not released on select rising");
  frame_length_a: assert property (falls_reg <= ACR_BITS_BUSY)
    else $error("frame ran past its last bit");
  frame_release_a: assert property (falls_reg == ACR_BITS_BUSY |-> ##[0:5] serial_data_out_oe_n)
    else $error("output held after last fall");
  bit_stable_a: assert property (sck && $past(sck) && !serial_data_out_oe_n
    && !$past(serial_data_out_oe_n) |-> $stable(serial_data_out_o)) else $error("bit moved");
  select_msb_a: assert property ($fell(select_chain_input) && convert_start
    && $past(convert_start, 6) |-> ##[1:8] !serial_data_out_oe_n) else $error("no msb");
  reset_idle_a: assert property ($rose(resetn) |-> serial_data_out_oe_n [*2])
    else $error("output driven after reset");

  cover property (falls_reg == ACR_BITS_BUSY);
  cover property ($fell(select_chain_input) && convert_start);
  cover property ($rose(convert_start) && select_chain_input);
endmodule

// >>> verif/adc_cs_mode_serial_readout_test.sv
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp); \
    end \
  end
module adc_cs_mode_serial_readout_test
  import acr_pkg::*;
;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic start = 1'b0;
  logic four_wire = 1'b0;
  logic use_busy = 1'b0;
  logic [15:0] sample_in = 16'h0000;
  logic [15:0] result;
  logic result_valid;
  logic host_busy;
  logic cs_mode;
  logic converting;
  logic conv_done;
  logic [15:0] got_word = 16'h0000;
  int vld_cnt = 0;
  int done_cnt = 0;
  int err_count = 0;
  int n_checks = 0;
  // Edge values after three mixed words: all zeros, all ones, lone low bit, lone top bit
  logic [15:0] vals [8] = '{16'h8001, 16'h7FFE, 16'hA5C3, 16'h0000,
                            16'hFFFF, 16'h0001, 16'h8000, 16'h5A3C};

  acr_link_if link ();
  acr_device acr_device_inst (.clk_sys(clk_sys), .resetn(resetn), .link(link.dev),
    .sample_in(sample_in), .cs_mode(cs_mode), .converting(converting), .conv_done(conv_done));
  acr_host acr_host_inst (.clk_sys(clk_sys), .resetn(resetn), .link(link.host), .start(start),
    .four_wire(four_wire), .use_busy(use_busy), .result(result), .result_valid(result_valid),
    .host_busy(host_busy));
  acr_link_properties acr_link_properties_inst (.clk_sys(clk_sys), .resetn(resetn),
    .convert_start(link.convert_start), .select_chain_input(link.select_chain_input),
    .sck(link.sck), .serial_data_out_o(link.serial_data_out_o),
    .serial_data_out_oe_n(link.serial_data_out_oe_n));

  always #50 clk_sys = ~clk_sys;

  // Words are counted, since the valid pulse may land while the frame is still releasing
  always @(negedge clk_sys)
  begin
    if (result_valid === 1'b1)
    begin
      got_word = result;
      vld_cnt++;
    end
    if (conv_done === 1'b1)
      done_cnt++;
  end

  task automatic report_and_stop();
    $display("Mismatches %0d, checks %0d", err_count, n_checks);
    if (err_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // One conversion and readback; the line is watched on the falling clock edge
  task automatic xfer(input logic fw, input logic bz, input logic [15:0] v);
    int n = 0;
    int falls = 0;
    int c0 = vld_cnt;
    int d0 = done_cnt;
    logic sck_q;
    // The word arrives before the last frame has let the line go: wait for release
    while (link.serial_data_out_oe_n !== 1'b1 && n < 300)
    begin
      @(negedge clk_sys);
      n++;
    end
    @(posedge clk_sys);
    four_wire <= fw;
    use_busy <= bz;
    sample_in <= v;
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    while (link.serial_data_out_oe_n !== 1'b0 && n < 300)
    begin
      @(negedge clk_sys);
      n++;
    end
    `CHK(link.serial_data_out_o, bz ? 1'b0 : v[15])
    while (link.serial_data_out_oe_n === 1'b0 && n < 600)
    begin
      sck_q = link.sck;
      @(negedge clk_sys);
      if (sck_q === 1'b1 && link.sck === 1'b0)
        falls++;
      n++;
    end
    `CHK(falls, bz ? 17 : 16)
    while (vld_cnt == c0 && n < 900)
    begin
      @(negedge clk_sys);
      n++;
    end
    `CHK(got_word, v)
    `CHK(cs_mode, 1'b1)
    `CHK(done_cnt - d0, 1)
    `CHK(converting, 1'b0)
    `CHK(host_busy, 1'b0)
  endtask

  // All four wirings twice, each started right after the last word
  initial
  begin
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int i = 0; i < 8; i++)
      xfer(i[1], i[0], vals[i]);
    report_and_stop();
  end

  // Eight frames need about 1500 cycles; over six times that means a hang
  initial
  begin
    #1000000;
    err_count++;
    $display("wrong value at %0t ns: run timed out", $time);
    report_and_stop();
  end
endmodule
